// [hw/osc_ctrl_pkg.sv]
package osc_ctrl_pkg;
	// timing, in ns and in system clock cycles
	localparam int SYS_CLK_NS = 100;
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_CYC = (GLITCH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [3:0] GLITCH_RUN = 4'(GLITCH_CYC);
	localparam int CAP_STEP_NS = 1000;
	localparam int CAP_STEP_CYC = (CAP_STEP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [3:0] CAP_STEP_LAST = 4'(CAP_STEP_CYC - 1);

	localparam logic [6:0] TARGET_ADDR = 7'h59;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// register addresses
	localparam logic [7:0] REG_CAP_HI = 8'h10;
	localparam logic [7:0] REG_CAP_LO = 8'h11;
	localparam logic [7:0] REG_FORMAT = 8'h15;
	localparam logic [7:0] REG_DIV_HI = 8'h16;
	localparam logic [7:0] REG_DIV_LO = 8'h17;
	localparam logic [7:0] REG_NUM_2 = 8'h1B;
	localparam logic [7:0] REG_NUM_1 = 8'h1C;
	localparam logic [7:0] REG_NUM_0 = 8'h1D;
	localparam logic [7:0] REG_NVM_CNT = 8'h30;
	localparam logic [7:0] REG_NVM_CTRL = 8'h31;
	localparam logic [7:0] REG_IND_ADDR = 8'h33;
	localparam logic [7:0] REG_NVM_DATA = 8'h34;
	localparam logic [7:0] REG_SRAM_DATA = 8'h35;
	localparam logic [7:0] REG_NVM_KEY = 8'h38;
	localparam logic [7:0] REG_STATUS = 8'h42;

	// slots of the configuration array, shared by live, shadow and nvm
	localparam int NCFG = 8;
	localparam logic [2:0] IDX_CAP_HI = 3'h0;
	localparam logic [2:0] IDX_CAP_LO = 3'h1;
	localparam logic [2:0] IDX_FORMAT = 3'h2;
	localparam logic [2:0] IDX_DIV_HI = 3'h3;
	localparam logic [2:0] IDX_DIV_LO = 3'h4;
	localparam logic [2:0] IDX_NUM_2 = 3'h5;
	localparam logic [2:0] IDX_NUM_1 = 3'h6;
	localparam logic [2:0] IDX_NUM_0 = 3'h7;

	localparam int CTRL_NVM_PROG_BIT = 0;
	localparam int CTRL_SRAM_COPY_BIT = 6;
	localparam logic [7:0] NVM_KEY = 8'hBE;
	localparam int STAT_LOL_BIT = 0;
	localparam int STAT_CAL_BIT = 1;

	localparam logic [8:0] DIV_MIN = 9'h005;
	localparam logic [7:0] NVM_INIT [NCFG] = '{8'h00, 8'h00, 8'h00,
		8'h00, 8'h10, 8'h00, 8'h00, 8'h00};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_REG = 3'b011,
		ST_WDATA = 3'b010,
		ST_RDATA = 3'b110
	} i2c_state_t;
endpackage

// [hw/pin_filter.sv]
`timescale 1ns/1ns
module pin_filter
	import osc_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level
);
	logic meta_reg;
	logic sync_reg;
	logic level_reg;
	logic [3:0] run_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= i_pin;
			sync_reg <= meta_reg;
		end
	end

	// a new level must hold one sample longer than the longest glitch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_reg <= 1'b1;
			run_reg <= 4'h0;
		end else if (sync_reg == level_reg) begin
			run_reg <= 4'h0;
		end else if (run_reg == GLITCH_RUN) begin
			level_reg <= sync_reg;
			run_reg <= 4'h0;
		end else begin
			run_reg <= run_reg + 4'h1;
		end
	end

	assign o_level = level_reg;
endmodule

// [hw/lock_monitor.sv]
`timescale 1ns/1ns
module lock_monitor
	import osc_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ref,
	input wire logic i_fb,
	output logic o_slip
);
	logic [1:0] ref_sync_reg;
	logic [1:0] fb_sync_reg;
	logic ref_d_reg;
	logic fb_d_reg;
	logic signed [2:0] diff_reg;
	logic signed [2:0] diff_next;
	logic slip_reg;
	logic ref_edge;
	logic fb_edge;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_sync_reg <= 2'h0;
			fb_sync_reg <= 2'h0;
			ref_d_reg <= 1'b0;
			fb_d_reg <= 1'b0;
		end else begin
			ref_sync_reg <= {ref_sync_reg[0], i_ref};
			fb_sync_reg <= {fb_sync_reg[0], i_fb};
			ref_d_reg <= ref_sync_reg[1];
			fb_d_reg <= fb_sync_reg[1];
		end
	end

	assign ref_edge = ref_sync_reg[1] & ~ref_d_reg;
	assign fb_edge = fb_sync_reg[1] & ~fb_d_reg;

	always_comb begin
		case ({ref_edge, fb_edge})
		2'b10: diff_next = diff_reg + 3'sd1;
		2'b01: diff_next = diff_reg - 3'sd1;
		default: diff_next = diff_reg;
		endcase
	end

	// edges are counted, not timed, so a slip of two cycles is caught
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			diff_reg <= 3'sd0;
			slip_reg <= 1'b0;
		end else if (diff_next >= 3'sd2 || diff_next <= -3'sd2) begin
			diff_reg <= 3'sd0;
			slip_reg <= 1'b1;
		end else begin
			diff_reg <= diff_next;
			slip_reg <= 1'b0;
		end
	end

	assign o_slip = slip_reg;
endmodule

// [hw/osc_i2c_control_port.sv]
`timescale 1ns/1ns
module osc_i2c_control_port
	import osc_ctrl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_ref_clk,
	input wire logic i_fb_clk,
	input wire logic i_cal_event,
	output logic [1:0] o_out_format,
	output logic [8:0] o_out_div,
	output logic [21:0] o_fb_num,
	output logic [15:0] o_load_cap,
	output logic o_div_clk,
	output logic o_lock_lost,
	output logic o_cal_flag
);
	logic scl_f;
	logic sda_f;
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	i2c_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic hack_reg;
	logic sda_oe_reg;
	logic wr_stb_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic rd_stb_reg;
	logic [7:0] rd_addr_reg;
	logic [7:0] rd_data;
	logic [3:0] wr_slot;
	logic boot_reg;
	logic [7:0] cfg_reg [NCFG];
	logic [7:0] sram_reg [NCFG];
	logic [7:0] nvm_reg [NCFG];
	logic [7:0] nvm_cnt_reg;
	logic [7:0] ind_addr_reg;
	logic [7:0] key_reg;
	logic ind_ok;
	logic ind_step;
	logic [1:0] format_reg;
	logic [8:0] div_reg;
	logic [8:0] div_cnt_reg;
	logic div_clk_reg;
	logic [21:0] num_reg;
	logic [15:0] cap_reg;
	logic [15:0] cap_target;
	logic [3:0] cap_tmr_reg;
	logic lol_reg;
	logic cal_reg;
	logic slip;
	logic clr_stat;
	logic skip_fall_reg;

	function automatic logic [3:0] cfg_slot(input logic [7:0] a);
		case (a)
		REG_CAP_HI: cfg_slot = {1'b1, IDX_CAP_HI};
		REG_CAP_LO: cfg_slot = {1'b1, IDX_CAP_LO};
		REG_FORMAT: cfg_slot = {1'b1, IDX_FORMAT};
		REG_DIV_HI: cfg_slot = {1'b1, IDX_DIV_HI};
		REG_DIV_LO: cfg_slot = {1'b1, IDX_DIV_LO};
		REG_NUM_2: cfg_slot = {1'b1, IDX_NUM_2};
		REG_NUM_1: cfg_slot = {1'b1, IDX_NUM_1};
		REG_NUM_0: cfg_slot = {1'b1, IDX_NUM_0};
		default: cfg_slot = 4'h0;
		endcase
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [3:0] s;
		s = cfg_slot(a);
		if (s[3]) begin
			rd_byte = cfg_reg[s[2:0]];
		end else begin
			case (a)
			REG_STATUS: rd_byte = {6'h00, cal_reg, lol_reg};
			REG_NVM_CNT: rd_byte = nvm_cnt_reg;
			REG_IND_ADDR: rd_byte = ind_addr_reg;
			REG_NVM_KEY: rd_byte = key_reg;
			REG_NVM_DATA: rd_byte = ind_ok ? nvm_reg[ind_addr_reg[2:0]] : 8'h00;
			REG_SRAM_DATA: rd_byte = ind_ok ? sram_reg[ind_addr_reg[2:0]] : 8'h00;
			default: rd_byte = 8'h00;
			endcase
		end
	endfunction

	pin_filter u_scl_filter (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_scl),
		.o_level(scl_f)
	);

	pin_filter u_sda_filter (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_sda),
		.o_level(sda_f)
	);

	lock_monitor u_lock_monitor (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ref(i_ref_clk),
		.i_fb(i_fb_clk),
		.o_slip(slip)
	);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_f;
			sda_d_reg <= sda_f;
		end
	end

	// filtered levels are sampled at 10 MHz, enough for fast mode
	assign scl_rise = scl_f & ~scl_d_reg;
	assign scl_fall = ~scl_f & scl_d_reg;
	assign start_c = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
	assign stop_c = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
	// a process, not an assign, so status and register changes are seen too
	always_comb begin
		rd_data = rd_byte(ptr_reg);
	end
	assign wr_slot = cfg_slot(wr_addr_reg);
	assign ind_ok = (ind_addr_reg[7:3] == 5'h00);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			hack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			wr_stb_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			rd_stb_reg <= 1'b0;
			rd_addr_reg <= 8'h00;
			skip_fall_reg <= 1'b0;
		end else begin
			wr_stb_reg <= 1'b0;
			rd_stb_reg <= 1'b0;
			if (stop_c) begin
				state_reg <= ST_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (start_c) begin
				// a repeated start keeps the register pointer
				state_reg <= ST_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
				skip_fall_reg <= 1'b1;
			end else if (state_reg != ST_IDLE) begin
				if (scl_rise) begin
					if (cnt_reg == ACK_SLOT) begin
						hack_reg <= ~sda_f;
					end else begin
						shift_reg <= {shift_reg[6:0], sda_f};
					end
				end
				// the scl fall that closes a start carries no bit
				if (scl_fall && skip_fall_reg) begin
					skip_fall_reg <= 1'b0;
				end else if (scl_fall) begin
					if (cnt_reg < 4'h7) begin
						cnt_reg <= cnt_reg + 4'h1;
						if (state_reg == ST_RDATA) begin
							sda_oe_reg <= ~tx_reg[3'h6 - cnt_reg[2:0]];
						end
					end else if (cnt_reg == 4'h7) begin
						cnt_reg <= ACK_SLOT;
						case (state_reg)
						ST_ADDR: begin
							if (shift_reg[7:1] == TARGET_ADDR) begin
								sda_oe_reg <= 1'b1;
								rw_reg <= shift_reg[0];
							end else begin
								state_reg <= ST_IDLE;
							end
						end
						ST_REG: begin
							sda_oe_reg <= 1'b1;
							ptr_reg <= shift_reg;
						end
						ST_WDATA: begin
							sda_oe_reg <= 1'b1;
							wr_stb_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= shift_reg;
							ptr_reg <= ptr_reg + 8'h01;
						end
						ST_RDATA: begin
							sda_oe_reg <= 1'b0;
							rd_stb_reg <= 1'b1;
							rd_addr_reg <= ptr_reg;
							ptr_reg <= ptr_reg + 8'h01;
						end
						default: state_reg <= ST_IDLE;
						endcase
					end else begin
						cnt_reg <= 4'h0;
						sda_oe_reg <= 1'b0;
						case (state_reg)
						ST_ADDR: begin
							if (rw_reg) begin
								state_reg <= ST_RDATA;
								tx_reg <= rd_data;
								sda_oe_reg <= ~rd_data[7];
							end else begin
								state_reg <= ST_REG;
							end
						end
						ST_REG: state_reg <= ST_WDATA;
						ST_WDATA: state_reg <= ST_WDATA;
						ST_RDATA: begin
							if (hack_reg) begin
								tx_reg <= rd_data;
								sda_oe_reg <= ~rd_data[7];
							end else begin
								state_reg <= ST_IDLE;
							end
						end
						default: state_reg <= ST_IDLE;
						endcase
					end
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
		end
	end

	// live registers: nvm image first, then host writes by slot
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NCFG; i++) begin
				cfg_reg[i] <= 8'h00;
			end
		end else if (boot_reg) begin
			for (int i = 0; i < NCFG; i++) begin
				cfg_reg[i] <= nvm_reg[i];
			end
		end else if (wr_stb_reg && wr_slot[3]) begin
			cfg_reg[wr_slot[2:0]] <= wr_data_reg;
		end
	end

	// outputs change only on a completed, valid update
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			format_reg <= 2'h0;
			div_reg <= DIV_MIN;
			num_reg <= 22'h000000;
		end else if (boot_reg) begin
			format_reg <= nvm_reg[IDX_FORMAT][1:0];
			div_reg <= {nvm_reg[IDX_DIV_HI][0], nvm_reg[IDX_DIV_LO]};
			num_reg <= {nvm_reg[IDX_NUM_2][5:0], nvm_reg[IDX_NUM_1],
				nvm_reg[IDX_NUM_0]};
		end else if (wr_stb_reg) begin
			case (wr_addr_reg)
			REG_FORMAT: format_reg <= wr_data_reg[1:0];
			REG_DIV_LO: begin
				if ({cfg_reg[IDX_DIV_HI][0], wr_data_reg} >= DIV_MIN) begin
					div_reg <= {cfg_reg[IDX_DIV_HI][0], wr_data_reg};
				end
			end
			REG_NUM_0: num_reg <= {cfg_reg[IDX_NUM_2][5:0],
				cfg_reg[IDX_NUM_1], wr_data_reg};
			default: num_reg <= num_reg;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_cnt_reg <= 9'h000;
			div_clk_reg <= 1'b0;
		end else begin
			if (div_cnt_reg >= div_reg - 9'h001) begin
				div_cnt_reg <= 9'h000;
			end else begin
				div_cnt_reg <= div_cnt_reg + 9'h001;
			end
			div_clk_reg <= (div_cnt_reg < {1'b0, div_reg[8:1]});
		end
	end

	// one code step per interval so the frequency never overshoots
	assign cap_target = {cfg_reg[IDX_CAP_HI], cfg_reg[IDX_CAP_LO]};
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_reg <= 16'h0000;
			cap_tmr_reg <= 4'h0;
		end else if (cap_tmr_reg != CAP_STEP_LAST) begin
			cap_tmr_reg <= cap_tmr_reg + 4'h1;
		end else begin
			cap_tmr_reg <= 4'h0;
			if (cap_reg < cap_target) begin
				cap_reg <= cap_reg + 16'h0001;
			end else if (cap_reg > cap_target) begin
				cap_reg <= cap_reg - 16'h0001;
			end
		end
	end

	// a new event wins over the clear of the read that just ended
	assign clr_stat = rd_stb_reg && (rd_addr_reg == REG_STATUS);
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lol_reg <= 1'b0;
			cal_reg <= 1'b0;
		end else begin
			lol_reg <= slip | (lol_reg & ~clr_stat);
			cal_reg <= i_cal_event | (cal_reg & ~clr_stat);
		end
	end

	assign ind_step = (wr_stb_reg && wr_addr_reg == REG_SRAM_DATA) ||
		(rd_stb_reg && (rd_addr_reg == REG_SRAM_DATA ||
		rd_addr_reg == REG_NVM_DATA));

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ind_addr_reg <= 8'h00;
			key_reg <= 8'h00;
		end else begin
			if (wr_stb_reg && wr_addr_reg == REG_IND_ADDR) begin
				ind_addr_reg <= wr_data_reg;
			end else if (ind_step) begin
				ind_addr_reg <= ind_addr_reg + 8'h01;
			end
			if (wr_stb_reg && wr_addr_reg == REG_NVM_KEY) begin
				key_reg <= wr_data_reg;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NCFG; i++) begin
				sram_reg[i] <= 8'h00;
			end
		end else if (wr_stb_reg && wr_addr_reg == REG_NVM_CTRL &&
			wr_data_reg[CTRL_SRAM_COPY_BIT]) begin
			for (int i = 0; i < NCFG; i++) begin
				sram_reg[i] <= cfg_reg[i];
			end
		end else if (wr_stb_reg && wr_addr_reg == REG_SRAM_DATA && ind_ok) begin
			sram_reg[ind_addr_reg[2:0]] <= wr_data_reg;
		end
	end

	// programming is refused unless the key byte is in place
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NCFG; i++) begin
				nvm_reg[i] <= NVM_INIT[i];
			end
			nvm_cnt_reg <= 8'h00;
		end else if (wr_stb_reg && wr_addr_reg == REG_NVM_CTRL &&
			wr_data_reg[CTRL_NVM_PROG_BIT] && key_reg == NVM_KEY) begin
			for (int i = 0; i < NCFG; i++) begin
				nvm_reg[i] <= sram_reg[i];
			end
			nvm_cnt_reg <= nvm_cnt_reg + 8'h01;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_reg;
	assign o_out_format = format_reg;
	assign o_out_div = div_reg;
	assign o_fb_num = num_reg;
	assign o_load_cap = cap_reg;
	assign o_div_clk = div_clk_reg;
	assign o_lock_lost = lol_reg;
	assign o_cal_flag = cal_reg;
endmodule

// [dv/osc_i2c_control_port_props.sv]
`timescale 1ns/1ns
module osc_i2c_control_port_props
	import osc_ctrl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_cal_event,
	input wire logic o_sda_oe,
	input wire logic [1:0] o_out_format,
	input wire logic [8:0] o_out_div,
	input wire logic [21:0] o_fb_num,
	input wire logic [15:0] o_load_cap,
	input wire logic o_lock_lost,
	input wire logic o_cal_flag
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence cap_step;
		(o_load_cap == $past(o_load_cap) + 16'h0001) ||
			(o_load_cap == $past(o_load_cap) - 16'h0001);
	endsequence
	// a step must be followed by a quiet spell, so no jump of two codes
	sequence cap_rest;
		$stable(o_load_cap) [*8];
	endsequence
	sequence oe_stand;
		o_sda_oe [*8];
	endsequence

	chk_div_floor: assert property (o_out_div >= DIV_MIN)
		else $error("divide below floor");
	chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda moved while scl high");
	chk_ack_stand: assert property ($rose(o_sda_oe) |-> oe_stand)
		else $error("sda drive too short");
	chk_cal_set: assert property (i_cal_event |=> o_cal_flag)
		else $error("cal event not flagged");
	chk_flags_clear: assert property ($fell(o_lock_lost) |->
		!o_cal_flag || $past(i_cal_event))
		else $error("flags not cleared together");
	chk_lost_hold: assert property (o_lock_lost && i_scl |=> o_lock_lost)
		else $error("lock flag dropped outside read");
	chk_fmt_low: assert property ($changed(o_out_format) |-> !$past(i_scl))
		else $error("format moved while scl high");
	chk_num_low: assert property ($changed(o_fb_num) |-> !$past(i_scl))
		else $error("numerator moved while scl high");
	chk_cap_walk: assert property ($changed(o_load_cap) |->
		cap_step ##1 cap_rest)
		else $error("load cap not walking by one");
endmodule

bind osc_i2c_control_port osc_i2c_control_port_props chk_u (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
	.i_cal_event(i_cal_event), .o_sda_oe(o_sda_oe),
	.o_out_format(o_out_format), .o_out_div(o_out_div),
	.o_fb_num(o_fb_num), .o_load_cap(o_load_cap),
	.o_lock_lost(o_lock_lost), .o_cal_flag(o_cal_flag)
);

// [dv/i2c_host_model.sv]
`timescale 1ns/1ns
module i2c_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// scl low is 6 cycles because the target answers 5 cycles after a fall
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe <= !b;
		q(4);
		o_scl <= 1'b1;
		q(1);
		r = i_sda;
		q(1);
		o_scl <= 1'b0;
		q(2);
	endtask
	task automatic start();
		if (o_scl === 1'b0) begin
			o_sda_oe <= 1'b0;
			q(4);
			o_scl <= 1'b1;
			q(4);
		end
		o_sda_oe <= 1'b1;
		q(4);
		o_scl <= 1'b0;
		q(4);
	endtask
	task automatic stop();
		o_sda_oe <= 1'b1;
		q(4);
		o_scl <= 1'b1;
		q(4);
		o_sda_oe <= 1'b0;
		q(8);
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
	// short scl spike that straddles one sampling edge
	task automatic glitch();
		q(2);
		#80 o_scl <= 1'b1;
		#40 o_scl <= 1'b0;
		q(1);
	endtask
endmodule

// [dv/osc_i2c_control_port_tb.sv]
`timescale 1ns/1ns
module osc_i2c_control_port_tb
	import osc_ctrl_pkg::*;
;
	logic i_sys_clk;
	logic i_rst_n;
	logic ref_clk;
	logic fb_clk;
	logic cal_ev;
	logic scl, host_oe, sda_oe, sda_out, div_clk, lost, calf;
	logic [1:0] fmt;
	logic [8:0] div;
	logic [21:0] num;
	logic [15:0] cap;
	wire sda = !(host_oe | sda_oe);
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [31:0] exp_q[$];
	logic [31:0] act_q[$];
	string nm_q[$];

	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	osc_i2c_control_port dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_ref_clk(ref_clk), .i_fb_clk(fb_clk), .i_cal_event(cal_ev),
		.o_out_format(fmt), .o_out_div(div), .o_fb_num(num),
		.o_load_cap(cap), .o_div_clk(div_clk), .o_lock_lost(lost),
		.o_cal_flag(calf));
	i2c_host_model host_u (.i_clk(i_sys_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(host_oe));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic ck(input string n, input logic [31:0] e,
		input logic [31:0] a);
		nm_q.push_back(n);
		exp_q.push_back(e);
		act_q.push_back(a);
	endtask
	always @(negedge i_sys_clk) begin
		while (act_q.size() > 0) begin
			total_checks++;
			if (act_q[0] !== exp_q[0]) begin
				n_mismatch++;
				$display("MISMATCH %s expected %h seen %h", nm_q[0], exp_q[0],
					act_q[0]);
			end
			void'(act_q.pop_front());
			void'(exp_q.pop_front());
			void'(nm_q.pop_front());
		end
	end
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic wbyte(input logic [7:0] d);
		logic ak;
		host_u.wr(d, ak);
		ck("data_ack", 32'h1, 32'(ak));
	endtask
	task automatic open_w(input logic [7:0] a);
		logic ak;
		host_u.start();
		host_u.wr({TARGET_ADDR, 1'b0}, ak);
		ck("addr_ack", 32'h1, 32'(ak));
		wbyte(a);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d[$]);
		open_w(a);
		foreach (d[i]) wbyte(d[i]);
		host_u.stop();
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e[$]);
		logic [7:0] v;
		logic ak;
		open_w(a);
		host_u.start();
		host_u.wr({TARGET_ADDR, 1'b1}, ak);
		ck("rd_ack", 32'h1, 32'(ak));
		foreach (e[i]) begin
			host_u.rd(i == e.size() - 1, v);
			ck("rd_data", 32'(e[i]), 32'(v));
		end
		host_u.stop();
		ck("released", 32'h0, 32'(sda_oe));
	endtask

	initial begin
		logic ak;
		logic [7:0] f;
		logic [21:0] n;
		int dv[4] = '{511, 4, 5, 18};
		int prev;
		int w;
		i_rst_n <= 1'b0;
		ref_clk <= 1'b0;
		fb_clk <= 1'b0;
		cal_ev <= 1'b0;
		void'($urandom(21));
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		host_u.q(12);
		ck("boot_div", 32'h10, 32'(div));
		ck("boot_fmt", 32'h0, 32'(fmt));
		host_u.start();
		host_u.wr(8'h46, ak);
		ck("foreign_ack", 32'h0, 32'(ak));
		host_u.stop();
		for (int i = 0; i < 4; i++) begin
			wreg(REG_FORMAT, '{8'(i)});
			ck("format", 32'(i), 32'(fmt));
		end
		f = {6'h00, 2'($urandom_range(2, 0))};
		open_w(REG_FORMAT);
		host_u.glitch();
		wbyte(f);
		host_u.stop();
		ck("glitch_fmt", 32'(f[1:0]), 32'(fmt));
		prev = 16;
		foreach (dv[i]) begin
			wreg(REG_DIV_HI, '{8'(dv[i] >> 8), 8'(dv[i])});
			if (dv[i] >= 5) prev = dv[i];
			ck("divide", 32'(prev), 32'(div));
		end
		// measured on the falling edge so the divider's updates have landed
		while (div_clk !== 1'b1) @(negedge i_sys_clk);
		while (div_clk === 1'b1) @(negedge i_sys_clk);
		for (w = 0; div_clk !== 1'b1; w++) @(negedge i_sys_clk);
		for (; div_clk === 1'b1; w++) @(negedge i_sys_clk);
		ck("div_period", 32'd18, 32'(w));
		n = 22'($urandom);
		open_w(REG_NUM_2);
		wbyte({2'b00, n[21:16]});
		wbyte(n[15:8]);
		ck("num_held", 32'h0, 32'(num));
		wbyte(n[7:0]);
		host_u.stop();
		ck("num", 32'(n), 32'(num));
		rreg(REG_FORMAT, '{f, 8'h00, 8'h12});
		wreg(8'h7F, '{8'hAA});
		rreg(8'h7F, '{8'h00});
		wreg(REG_NVM_CNT, '{8'h55});
		rreg(REG_NVM_CNT, '{8'h00});
		wreg(REG_CAP_HI, '{8'h00, 8'h06});
		host_u.q(70);
		ck("cap_up", 32'h6, 32'(cap));
		wreg(REG_CAP_LO, '{8'h02});
		host_u.q(50);
		ck("cap_down", 32'h2, 32'(cap));
		for (int i = 0; i < 8; i++) begin
			ref_clk <= 1'b1;
			fb_clk <= (i < 6);
			host_u.q(4);
			ref_clk <= 1'b0;
			fb_clk <= 1'b0;
			host_u.q(4);
			if (i == 5) ck("locked", 32'h0, 32'(lost));
		end
		cal_ev <= 1'b1;
		host_u.q(1);
		cal_ev <= 1'b0;
		host_u.q(50);
		ck("lost_held", 32'h1, 32'(lost));
		ck("cal_held", 32'h1, 32'(calf));
		rreg(REG_STATUS, '{8'h03});
		ck("lost_clr", 32'h0, 32'(lost));
		ck("cal_clr", 32'h0, 32'(calf));
		rreg(REG_STATUS, '{8'h00});
		host_u.q(4);
		report_and_stop();
	end
endmodule
